// file: hw/ccu_controller.sv
// Supervisory controller of a portable cooling unit: relays, fan speeds, protection and alarms.
// Assumes thermostat, switch and float inputs are clean levels synchronous to mclk and that
// temperature codes are valid every cycle. Relay drivers and alarm wiring are outside.
module ccu_controller
    import ccu_pkg::*;
#(
    parameter int TICK_CYCLES = CCU_TICK_CYCLES
) (
    input wire logic mclk,                          // System clock, 125 MHz.
    input wire logic srst,                          // Synchronous reset, active high; power-up.
    input wire logic cool_call,                     // Thermostat compressor demand.
    input wire logic fan_call,                      // Thermostat fan call.
    input wire logic low_speed_select,              // Thermostat evaporator low-speed select.
    input wire ccu_temp_type evap_inlet_sensor,     // Evaporator inlet temperature code.
    input wire ccu_temp_type freeze_sensor,         // Freeze protection temperature code.
    input wire ccu_temp_type condenser_inlet_sensor, // Condenser inlet temperature code.
    input wire logic fan_test_switch,               // Configuration switch one.
    input wire logic cooling_test_switch,           // Configuration switch two.
    input wire logic delay_bypass_switch,           // Configuration switch three.
    input wire logic buzzer_mute_switch,            // Configuration switch four.
    input wire logic float_active,                  // Drain pan float switch, high when full.
    input wire logic fire_alarm,                    // Fire alarm panel input, high when alarming.
    output logic compressor_relay,                  // Compressor relay drive.
    output logic evap_fan_relay,                    // Evaporator fan on relay drive.
    output logic aux_relay,                         // Auxiliary relay, condenser fan on.
    output logic evap_fan_low,                      // Evaporator fan speed relay, high selects low speed.
    output logic cond_fan_high,                     // Condenser fan speed, high selects high speed.
    output logic drain_pump,                        // Drain pump drive.
    output logic buzzer,                            // Buzzer sound output.
    output logic warning_relay,                     // Warning signal relay drive.
    output logic sensor_short,                      // Latched shorted-sensor fault.
    output logic sensor_open,                       // Latched open-sensor fault.
    output logic overflow_alarm,                    // Latched condensation overflow alarm.
    output logic fire_lockout,                      // Unit held off by fire alarm.
    output logic antifrost_active                   // Anti-frost hold on the compressor.
);

    ccu_state_type s_q;
    ccu_state_type s_d;
    logic tick_en;
    logic stop;
    logic fan_req;
    logic demand;

    function automatic logic ccu_is_short(input ccu_temp_type t);
        return t >= CCU_SHORT_CODE;
    endfunction

    function automatic logic ccu_is_open(input ccu_temp_type t);
        return t <= CCU_OPEN_CODE;
    endfunction

    ccu_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .srst(srst),
        .tick_en(tick_en)
    );

    always_comb
    begin
        s_d = s_q;

        // Sensor faults latch; only reset clears them.
        s_d.short_f = s_q.short_f | ccu_is_short(evap_inlet_sensor) | ccu_is_short(freeze_sensor);
        s_d.open_f = s_q.open_f | ccu_is_open(evap_inlet_sensor) | ccu_is_open(freeze_sensor);

        // The count restarts whenever the float drops, so only an unbroken full pan trips.
        if (!float_active)
        begin
            s_d.flt_cnt = '0;
        end
        else if (tick_en && s_q.flt_cnt != CCU_FLOAT_TICKS)
        begin
            s_d.flt_cnt = s_q.flt_cnt + 6'h01;
        end
        s_d.overflow = s_q.overflow | (s_d.flt_cnt == CCU_FLOAT_TICKS);

        // A new alarm wins over the release by the fan call going low.
        s_d.fire_lock = fire_alarm | (s_q.fire_lock & fan_call);

        stop = s_d.short_f | s_d.open_f | s_d.overflow | s_d.fire_lock;
        fan_req = (fan_call | fan_test_switch | cooling_test_switch) & ~stop;
        demand = ((fan_call & cool_call) | cooling_test_switch) & ~stop;

        // Anti-frost runs its own timer so that a short dip still holds the compressor 15 minutes.
        if (!s_q.af)
        begin
            if (freeze_sensor < CCU_AF_ENTER_CODE)
            begin
                s_d.af = 1'b1;
                s_d.af_cnt = '0;
            end
        end
        else
        begin
            if (tick_en && s_q.af_cnt != CCU_AF_TICKS)
            begin
                s_d.af_cnt = s_q.af_cnt + 10'h001;
            end
            if (freeze_sensor >= CCU_AF_EXIT_CODE && s_q.af_cnt == CCU_AF_TICKS)
            begin
                s_d.af = 1'b0;
            end
        end

        // Restart delay. After reset the sequencer is idle, so the first demand waits too.
        unique case (s_q.cmp)
            CMP_IDLE:
            begin
                if (demand)
                begin
                    s_d.dly = CCU_DLY_TICKS;
                    s_d.cmp = delay_bypass_switch ? CMP_RUN : CMP_WAIT;
                end
            end
            CMP_WAIT:
            begin
                if (!demand)
                begin
                    s_d.cmp = CMP_IDLE;
                end
                else if (delay_bypass_switch || s_q.dly == '0)
                begin
                    s_d.cmp = CMP_RUN;
                end
                else if (tick_en)
                begin
                    s_d.dly = s_q.dly - 8'h01;
                end
            end
            CMP_RUN:
            begin
                if (!demand)
                begin
                    s_d.cmp = CMP_IDLE;
                end
            end
            default:
            begin
                s_d.cmp = CMP_IDLE;
            end
        endcase

        // Condenser speed hysteresis; between the thresholds the last choice stands.
        if (condenser_inlet_sensor >= CCU_COND_HI_CODE)
        begin
            s_d.cond_high = 1'b1;
        end
        else if (condenser_inlet_sensor <= CCU_COND_LO_CODE)
        begin
            s_d.cond_high = 1'b0;
        end

        // A starting condenser fan gets a high-speed burst before it may drop to low.
        if (fan_req && !s_q.evap)
        begin
            s_d.hold = CCU_HOLD_TICKS;
        end
        else if (!fan_req)
        begin
            s_d.hold = '0;
        end
        else if (tick_en && s_q.hold != '0)
        begin
            s_d.hold = s_q.hold - 3'h1;
        end

        s_d.comp = (s_d.cmp == CMP_RUN) & ~s_d.af;
        s_d.evap = fan_req;
        s_d.aux = fan_req;
        s_d.evap_low = fan_req & low_speed_select;
        s_d.cond_fast = fan_req & (s_d.cond_high | (s_d.hold != '0));
        s_d.drain = s_d.comp;
        s_d.warn = s_d.short_f | s_d.open_f | s_d.overflow;
        s_d.buzzer = (s_d.warn | s_d.fire_lock) & ~buzzer_mute_switch;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s_q <= CCU_STATE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign compressor_relay = s_q.comp;
    assign evap_fan_relay = s_q.evap;
    assign aux_relay = s_q.aux;
    assign evap_fan_low = s_q.evap_low;
    assign cond_fan_high = s_q.cond_fast;
    assign drain_pump = s_q.drain;
    assign buzzer = s_q.buzzer;
    assign warning_relay = s_q.warn;
    assign sensor_short = s_q.short_f;
    assign sensor_open = s_q.open_f;
    assign overflow_alarm = s_q.overflow;
    assign fire_lockout = s_q.fire_lock;
    assign antifrost_active = s_q.af;

endmodule

// file: hw/ccu_pkg.sv
// Constants and types shared by the cooling unit controller and its timebase.
// Assumes a single 125 MHz clock and temperature codes from an external converter.
package ccu_pkg;

    // System clock and the one-second timebase derived from it.
    localparam int CCU_CLK_HZ = 125_000_000;
    localparam int CCU_TICK_S = 1;
    localparam int CCU_TICK_CYCLES = CCU_CLK_HZ * CCU_TICK_S;

    // Temperature codes are signed two's complement, CCU_TEMP_SCALE codes per degree Celsius.
    localparam int CCU_TEMP_W = 10;
    localparam int CCU_TEMP_SCALE = 4;
    typedef logic signed [CCU_TEMP_W-1:0] ccu_temp_type;

    // Thresholds in whole degrees Celsius, then as codes.
    localparam int CCU_COND_HI_DEGC = 25;
    localparam int CCU_COND_LO_DEGC = 23;
    localparam int CCU_AF_ENTER_DEGC = -1;
    localparam int CCU_AF_EXIT_DEGC = 10;
    localparam int CCU_SHORT_DEGC = 83;
    localparam int CCU_OPEN_DEGC = -34;
    localparam ccu_temp_type CCU_COND_HI_CODE = ccu_temp_type'(CCU_COND_HI_DEGC * CCU_TEMP_SCALE);
    localparam ccu_temp_type CCU_COND_LO_CODE = ccu_temp_type'(CCU_COND_LO_DEGC * CCU_TEMP_SCALE);
    localparam ccu_temp_type CCU_AF_ENTER_CODE = ccu_temp_type'(CCU_AF_ENTER_DEGC * CCU_TEMP_SCALE);
    localparam ccu_temp_type CCU_AF_EXIT_CODE = ccu_temp_type'(CCU_AF_EXIT_DEGC * CCU_TEMP_SCALE);
    localparam ccu_temp_type CCU_SHORT_CODE = ccu_temp_type'(CCU_SHORT_DEGC * CCU_TEMP_SCALE);
    localparam ccu_temp_type CCU_OPEN_CODE = ccu_temp_type'(CCU_OPEN_DEGC * CCU_TEMP_SCALE);

    // Intervals in seconds. The tick phase is free running, so one extra tick makes each a least time.
    localparam int CCU_RESTART_DELAY_S = 120;
    localparam int CCU_AF_MIN = 15;
    localparam int CCU_AF_S = CCU_AF_MIN * 60;
    localparam int CCU_COND_HOLD_S = 5;
    localparam int CCU_FLOAT_S = 60;
    localparam logic [7:0] CCU_DLY_TICKS = 8'(CCU_RESTART_DELAY_S + 1);
    localparam logic [9:0] CCU_AF_TICKS = 10'(CCU_AF_S + 1);
    localparam logic [2:0] CCU_HOLD_TICKS = 3'(CCU_COND_HOLD_S + 1);
    localparam logic [5:0] CCU_FLOAT_TICKS = 6'(CCU_FLOAT_S + 1);

    // Compressor sequencing.
    typedef enum logic [1:0] {CMP_IDLE, CMP_WAIT, CMP_RUN} ccu_cmp_type;

    typedef struct packed {
        ccu_cmp_type cmp;
        logic [7:0] dly;
        logic af;
        logic [9:0] af_cnt;
        logic cond_high;
        logic [2:0] hold;
        logic [5:0] flt_cnt;
        logic overflow;
        logic short_f;
        logic open_f;
        logic fire_lock;
        logic comp;
        logic evap;
        logic aux;
        logic evap_low;
        logic cond_fast;
        logic drain;
        logic buzzer;
        logic warn;
    } ccu_state_type;

    localparam ccu_state_type CCU_STATE_RST = '0;

endpackage

// file: hw/ccu_tick.sv
// One-cycle enable pulse every TICK_CYCLES clocks, the slow timebase of the controller.
// Assumes a synchronous active-high reset on the same clock.
module ccu_tick #(
    parameter int TICK_CYCLES = 125_000_000
) (
    input wire logic mclk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    output logic tick_en   // One-cycle pulse per tick period.
);

    localparam int CNT_W = $clog2(TICK_CYCLES);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb
    begin
        cnt_d = cnt_q + 1'b1;
        tick_d = 1'b0;
        if (cnt_q == LAST)
        begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_en = tick_q;

endmodule

// file: tb/ccu_controller_props.sv
// Concurrent checks on the controller pins, bound into every controller instance.
// Assumes one clock and a synchronous reset; all outputs come straight from flip-flops.
module ccu_controller_props
    import ccu_pkg::*;
#(
    parameter int TICK_CYCLES = CCU_TICK_CYCLES
) (
    input wire logic mclk, // Clock.
    input wire logic srst, // Reset.
    input wire logic fan_call, // Fan call.
    input wire logic low_speed_select, // Low speed.
    input wire ccu_temp_type evap_inlet_sensor, // Inlet code.
    input wire ccu_temp_type freeze_sensor, // Freeze code.
    input wire logic fan_test_switch, // Switch one.
    input wire logic cooling_test_switch, // Switch two.
    input wire logic buzzer_mute_switch, // Switch four.
    input wire logic fire_alarm, // Fire input.
    input wire logic compressor_relay, // Compressor.
    input wire logic evap_fan_relay, // Evaporator fan.
    input wire logic aux_relay, // Condenser fan.
    input wire logic evap_fan_low, // Low speed relay.
    input wire logic drain_pump, // Pump.
    input wire logic buzzer, // Buzzer.
    input wire logic sensor_short, // Short fault.
    input wire logic sensor_open, // Open fault.
    input wire logic overflow_alarm, // Overflow.
    input wire logic fire_lockout, // Fire hold.
    input wire logic antifrost_active // Anti-frost.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    sequence s_fire_in;
        fire_alarm;
    endsequence
    sequence s_unit_off;
        fire_lockout && !compressor_relay && !evap_fan_relay && !aux_relay;
    endsequence
    a_fan_off_stop: assert property (!fan_call && !fan_test_switch && !cooling_test_switch
        |=> !compressor_relay && !evap_fan_relay) else $error("relay kept after fan call dropped");
    a_fan_call_on: assert property (fan_call && !fire_alarm |=> (evap_fan_relay && aux_relay)
        || sensor_short || sensor_open || overflow_alarm || fire_lockout) else $error("fans not on");
    a_low_speed_follow: assert property (fan_call |=>
        !evap_fan_relay || evap_fan_low == $past(low_speed_select)) else $error("fan speed wrong");
    a_drain_with_comp: assert property (drain_pump == compressor_relay)
        else $error("drain pump differs from compressor");
    a_frost_cut: assert property (freeze_sensor < CCU_AF_ENTER_CODE && freeze_sensor > CCU_OPEN_CODE
        |=> antifrost_active ##1 !compressor_relay) else $error("anti-frost did not stop compressor");
    a_short_detect: assert property (evap_inlet_sensor >= CCU_SHORT_CODE || freeze_sensor >= CCU_SHORT_CODE
        |=> sensor_short) else $error("short not flagged");
    a_open_detect: assert property (evap_inlet_sensor <= CCU_OPEN_CODE || freeze_sensor <= CCU_OPEN_CODE
        |=> sensor_open) else $error("open not flagged");
    a_fault_stop: assert property (sensor_short || sensor_open |->
        !compressor_relay && !evap_fan_relay && !aux_relay) else $error("unit runs with sensor fault");
    a_buzzer_mute: assert property (buzzer_mute_switch |=> !buzzer)
        else $error("buzzer sounds while muted");
    a_buzzer_alarm: assert property ((sensor_short || sensor_open || overflow_alarm) && !buzzer_mute_switch
        |=> buzzer) else $error("buzzer silent on alarm");
    a_fire_hold: assert property (s_fire_in |=> s_unit_off)
        else $error("unit not held off by fire alarm");
endmodule

bind ccu_controller ccu_controller_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.mclk, .srst, .fan_call,
    .low_speed_select, .evap_inlet_sensor, .freeze_sensor, .fan_test_switch, .cooling_test_switch,
    .buzzer_mute_switch, .fire_alarm, .compressor_relay, .evap_fan_relay, .aux_relay, .evap_fan_low,
    .drain_pump, .buzzer, .sensor_short, .sensor_open, .overflow_alarm, .fire_lockout, .antifrost_active);

// file: tb/ccu_stat_model.sv
// Wall thermostat contacts and unit thermistors as the controller sees them.
// Assumes the bench sets wanted levels in degrees at the falling edge; they reach the pins in that same step.
module ccu_stat_model
    import ccu_pkg::*;
(
    input wire logic [2:0] want, // Wanted fan, cool and low-speed contacts.
    input var int t_evap, // Evaporator inlet, degrees.
    input var int t_frz, // Freeze sensor, degrees.
    input var int t_cond, // Condenser inlet, degrees.
    output logic fan_call, // Fan contact.
    output logic cool_call, // Cooling contact.
    output logic low_speed_select, // Low-speed contact.
    output ccu_temp_type evap_inlet_sensor, // Inlet code.
    output ccu_temp_type freeze_sensor, // Freeze code.
    output ccu_temp_type condenser_inlet_sensor // Condenser code.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins follow the bench at once: sampling on the same falling edge as the bench would race its update.
    assign {fan_call, cool_call, low_speed_select} = want;
    // The converter rounds nothing: whole degrees map exactly onto codes.
    assign evap_inlet_sensor = ccu_temp_type'(t_evap * CCU_TEMP_SCALE);
    assign freeze_sensor = ccu_temp_type'(t_frz * CCU_TEMP_SCALE);
    assign condenser_inlet_sensor = ccu_temp_type'(t_cond * CCU_TEMP_SCALE);
endmodule

// file: tb/tb_ccu_controller.sv
// Self-checking bench for the cooling unit controller with a shortened one-second tick.
// Assumes the thermostat model drives calls and codes; switches and alarms come from here.
module tb_ccu_controller
    import ccu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    localparam int O_CMP = 12, O_EVP = 11, O_AUX = 10, O_LOW = 9, O_CND = 8, O_DRN = 7;
    localparam int O_BUZ = 6, O_WRN = 5, O_SHT = 4, O_OPN = 3, O_OVF = 2, O_FIR = 1, O_AF = 0;
    logic mclk = 1'b0, srst = 1'b1, fan_test_switch = 1'b0, cooling_test_switch = 1'b0;
    logic delay_bypass_switch = 1'b0, buzzer_mute_switch = 1'b0, float_active = 1'b0, fire_alarm = 1'b0;
    logic [2:0] want = 3'h0;
    int t_evap = 25, t_frz = 20, t_cond = 20, num_errors = 0, compares = 0, n, n2;
    int cond_t[4] = '{25, 24, 23, 24};
    logic cond_e[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic fan_call, cool_call, low_speed_select;
    ccu_temp_type evap_inlet_sensor, freeze_sensor, condenser_inlet_sensor;
    logic compressor_relay, evap_fan_relay, aux_relay, evap_fan_low, cond_fan_high, drain_pump, buzzer;
    logic warning_relay, sensor_short, sensor_open, overflow_alarm, fire_lockout, antifrost_active;
    wire logic [12:0] outs = {compressor_relay, evap_fan_relay, aux_relay, evap_fan_low, cond_fan_high,
        drain_pump, buzzer, warning_relay, sensor_short, sensor_open, overflow_alarm, fire_lockout, antifrost_active};

    always #4 mclk = ~mclk;

    ccu_stat_model stat (.want, .t_evap, .t_frz, .t_cond, .fan_call, .cool_call, .low_speed_select,
        .evap_inlet_sensor, .freeze_sensor, .condenser_inlet_sensor);
    ccu_controller #(.TICK_CYCLES(TK)) dut (.mclk, .srst, .cool_call, .fan_call, .low_speed_select,
        .evap_inlet_sensor, .freeze_sensor, .condenser_inlet_sensor, .fan_test_switch, .cooling_test_switch,
        .delay_bypass_switch, .buzzer_mute_switch, .float_active, .fire_alarm, .compressor_relay, .evap_fan_relay,
        .aux_relay, .evap_fan_low, .cond_fan_high, .drain_pump, .buzzer, .warning_relay, .sensor_short,
        .sensor_open, .overflow_alarm, .fire_lockout, .antifrost_active);

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A wait that runs out ends the run at once, since later steps rely on its result.
    task automatic wt(input int i, input logic v, input int lim, output int k);
        k = 0;
        while (outs[i] !== v && k < lim)
        begin
            cyc(1);
            k++;
        end
        if (outs[i] !== v)
        begin
            chk(outs[i], v);
            end_sim();
        end
    endtask

    task automatic rst();
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        cyc(1);
    endtask

    initial
    begin
        cyc(2);
        srst = 1'b0;
        cyc(2);
        chk(outs, 13'h0000);
        want = 3'b110;
        cyc(2);
        chk({outs[O_EVP], outs[O_AUX], outs[O_CMP], outs[O_LOW]}, 4'b1100);
        wt(O_CND, 1'b0, TK * 8, n);
        chk(13'(n + 2 >= 5 * TK), 13'h1);
        wt(O_CMP, 1'b1, TK * 125, n2);
        chk(13'(n + n2 + 2 >= 120 * TK), 13'h1);
        chk(outs[O_DRN], 1'b1);
        want = 3'b100;
        cyc(2);
        chk({outs[O_CMP], outs[O_DRN]}, 2'b00);
        want = 3'b110;
        wt(O_CMP, 1'b1, TK * 125, n);
        chk(13'(n >= 120 * TK), 13'h1);
        want = 3'b111;
        cyc(2);
        chk(outs[O_LOW], 1'b1);
        want = 3'b110;
        cyc(2);
        chk(outs[O_LOW], 1'b0);
        foreach (cond_t[i])
        begin
            t_cond = cond_t[i];
            cyc(2);
            chk(outs[O_CND], cond_e[i]);
        end
        want = 3'b010;
        cyc(2);
        chk({outs[O_CMP], outs[O_EVP], outs[O_AUX], outs[O_DRN]}, 4'b0000);
        delay_bypass_switch = 1'b1;
        want = 3'b110;
        cyc(3);
        chk(outs[O_CMP], 1'b1);
        t_frz = -2;
        cyc(3);
        chk({outs[O_CMP], outs[O_AF]}, 2'b01);
        t_frz = 10;
        wt(O_CMP, 1'b1, TK * 910, n);
        chk(13'(n >= 900 * TK), 13'h1);
        chk(outs[O_AF], 1'b0);
        want = 3'b000;
        fan_test_switch = 1'b1;
        cyc(2);
        chk({outs[O_CMP], outs[O_EVP], outs[O_AUX]}, 3'b011);
        fan_test_switch = 1'b0;
        cooling_test_switch = 1'b1;
        cyc(3);
        chk({outs[O_CMP], outs[O_EVP], outs[O_AUX]}, 3'b111);
        cooling_test_switch = 1'b0;
        delay_bypass_switch = 1'b0;
        cyc(TK * 8);
        chk(outs, 13'h0000);
        t_evap = 82;
        want = 3'b110;
        cyc(2);
        chk(outs[O_SHT], 1'b0);
        t_evap = 83;
        cyc(2);
        chk({outs[O_CMP], outs[O_EVP], outs[O_AUX], outs[O_BUZ], outs[O_WRN], outs[O_SHT]}, 6'h07);
        t_evap = 25;
        cyc(2);
        chk(outs[O_SHT], 1'b1);
        rst();
        buzzer_mute_switch = 1'b1;
        t_frz = -34;
        cyc(3);
        chk({outs[O_BUZ], outs[O_WRN], outs[O_OPN]}, 3'b011);
        buzzer_mute_switch = 1'b0;
        t_frz = 20;
        rst();
        cyc(1);
        chk(outs[O_EVP], 1'b1);
        float_active = 1'b1;
        wt(O_OVF, 1'b1, TK * 64, n);
        chk(13'(n >= 60 * TK), 13'h1);
        chk({outs[O_EVP], outs[O_WRN]}, 2'b01);
        float_active = 1'b0;
        rst();
        fire_alarm = 1'b1;
        cyc(2);
        chk({outs[O_FIR], outs[O_EVP], outs[O_AUX], outs[O_CMP]}, 4'b1000);
        fire_alarm = 1'b0;
        cyc(2);
        chk(outs[O_FIR], 1'b1);
        want = 3'b000;
        cyc(2);
        want = 3'b100;
        cyc(3);
        chk({outs[O_FIR], outs[O_EVP]}, 2'b01);
        end_sim();
    end
endmodule
